// ---- hw/global_pin_control_sync.sv ----
// Global pin control: reset, enable, phase sync, fault pin and PWM outputs
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module global_pin_control_sync (
	// Clock and reset
	input  wire logic                                    sys_clk,
	input  wire logic                                    reset_n,
	// Device pins and supply monitor
	input  wire logic                                    reset_pin_n,
	input  wire logic                                    enable_pin,
	input  wire logic                                    phase_sync_pin,
	input  wire logic                                    supply_ok,
	// Fault sources from the channel diagnostics
	input  wire logic [pin_ctrl_pkg::CHANNELS-1:0]       fault_in,
	// Register port
	input  wire logic [pin_ctrl_pkg::ADDR_W-1:0]         reg_addr,
	input  wire logic [31:0]                             reg_wdata,
	input  wire logic                                    reg_wr,
	input  wire logic                                    reg_rd,
	output logic      [31:0]                             reg_rdata,
	// Channel outputs, fault pin and interrupt
	output logic      [pin_ctrl_pkg::CHANNELS-1:0]       pwm_out,
	output logic                                         fault_pin_out,
	output logic                                         fault_pin_oe,
	output logic                                         irq
);
	localparam int N = pin_ctrl_pkg::CHANNELS;

	// ************************************************************
	// Declarations
	// ************************************************************
	logic [3:0]                              pins_sync;
	logic                                    rst_pin_s;
	logic                                    enable_s;
	logic                                    sync_s;
	logic                                    supply_s;
	logic                                    rst_pin_prev_q;
	logic                                    enable_prev_q;
	logic                                    sync_prev_q;
	logic                                    core_rst;
	logic                                    sync_rise;
	logic                                    reset_fall;
	logic                                    enable_fall;
	logic [pin_ctrl_pkg::SLOT_W-1:0]         slot_len_q;
	logic [pin_ctrl_pkg::SLOT_W-1:0]         slot_wr_val;
	logic [N-1:0]                            hold_sel_q;
	logic [N-1:0]                            fault_mask_q;
	logic [2:0]                              gen_flags_q;
	logic [pin_ctrl_pkg::IRQ_W-1:0]          irq_status_q;
	logic [pin_ctrl_pkg::IRQ_W-1:0]          irq_mask_q;
	logic [pin_ctrl_pkg::IRQ_W-1:0]          irq_events;
	logic [pin_ctrl_pkg::PHASE_W-1:0]        phase_q [N];
	logic [pin_ctrl_pkg::DUTY_W-1:0]         duty_q [N];
	logic [N-1:0]                            pwm_raw;
	logic                                    fault_active;
	logic                                    fault_active_prev_q;
	logic                                    rd_flags;
	logic                                    rd_irq;
	logic [31:0]                             rdata_d;

	timebase_if tb_link ();

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	// Every asynchronous pin passes two flops before use
	pin_sync #(
		.WIDTH      (4)
	) u_pin_sync (
		.sys_clk    (sys_clk),
		.reset_n    (reset_n),
		.pin_in     ({supply_ok, phase_sync_pin, enable_pin, reset_pin_n}),
		.pin_sync_q (pins_sync)
	);

	assign rst_pin_s = pins_sync[0];
	assign enable_s  = pins_sync[1];
	assign sync_s    = pins_sync[2];
	assign supply_s  = pins_sync[3];

	// ************************************************************
	// Reset combination and edge detection
	// ************************************************************
	// Pin reset or supply drop hold the core at defaults
	assign core_rst = !reset_n || !rst_pin_s || !supply_s;

	// Edge detection on the synchronised levels only
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			rst_pin_prev_q <= 1'b0;
			enable_prev_q  <= 1'b0;
			sync_prev_q    <= 1'b0;
		end
		else
		begin
			rst_pin_prev_q <= rst_pin_s;
			enable_prev_q  <= enable_s;
			sync_prev_q    <= sync_s;
		end
	end

	assign sync_rise   = sync_s && !sync_prev_q;
	assign reset_fall  = !rst_pin_s && rst_pin_prev_q;
	assign enable_fall = !enable_s && enable_prev_q;

	// ************************************************************
	// PWM timebase
	// ************************************************************
	// Sync rising edge restarts the period
	assign tb_link.restart  = sync_rise;
	assign tb_link.slot_len = slot_len_q;

	// All PWM timing counts main clock cycles
	pwm_timebase u_timebase (
		.sys_clk  (sys_clk),
		.core_rst (core_rst),
		.tb       (tb_link.source)
	);

	// ************************************************************
	// Configuration registers
	// ************************************************************
	// Slot length held inside the 10 Hz to 8000 Hz PWM range
	always_comb
	begin
		slot_wr_val = reg_wdata[pin_ctrl_pkg::SLOT_W-1:0];
		if (slot_wr_val < pin_ctrl_pkg::SLOT_MIN)
			slot_wr_val = pin_ctrl_pkg::SLOT_MIN;
		else if (slot_wr_val > pin_ctrl_pkg::SLOT_MAX)
			slot_wr_val = pin_ctrl_pkg::SLOT_MAX;
	end

	// Register writes; accepted only on the main clock
	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
		begin
			slot_len_q   <= pin_ctrl_pkg::SLOT_DEF;
			hold_sel_q   <= pin_ctrl_pkg::HOLD_SEL_DEF;
			fault_mask_q <= pin_ctrl_pkg::FAULT_MASK_DEF;
			irq_mask_q   <= pin_ctrl_pkg::IRQ_MASK_DEF;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				pin_ctrl_pkg::REG_SLOT_LEN:   slot_len_q   <= slot_wr_val;
				pin_ctrl_pkg::REG_HOLD_SEL:   hold_sel_q   <= reg_wdata[N-1:0];
				pin_ctrl_pkg::REG_FAULT_MASK: fault_mask_q <= reg_wdata[N-1:0];
				pin_ctrl_pkg::REG_IRQ_MASK:
					irq_mask_q <= reg_wdata[pin_ctrl_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// Per-channel phase delay, duty and output
	// ************************************************************
	for (genvar g = 0; g < N; g++)
	begin : g_chan
		logic [pin_ctrl_pkg::PHASE_W-1:0] rel_slot;

		// Phase delay and duty words of this channel
		always_ff @(posedge sys_clk)
		begin
			if (core_rst)
			begin
				phase_q[g] <= pin_ctrl_pkg::PHASE_DEF;
				duty_q[g]  <= pin_ctrl_pkg::DUTY_DEF;
			end
			else if (reg_wr)
			begin
				if (reg_addr == pin_ctrl_pkg::REG_PHASE_BASE + 8'(4 * g))
					phase_q[g] <= reg_wdata[pin_ctrl_pkg::PHASE_W-1:0];
				if (reg_addr == pin_ctrl_pkg::REG_DUTY_BASE + 8'(4 * g))
					duty_q[g] <= reg_wdata[pin_ctrl_pkg::DUTY_W-1:0];
			end
		end

		// Period starts phase_q slots after sync, slot = period/32
		assign rel_slot   = tb_link.slot_idx - phase_q[g];
		assign pwm_raw[g] = ({1'b0, rel_slot} < duty_q[g]);

		// Enable low: off, or freeze last state when hold is chosen
		always_ff @(posedge sys_clk)
		begin
			if (core_rst)
				pwm_out[g] <= 1'b0;
			else if (enable_s)
				pwm_out[g] <= pwm_raw[g];
			else if (!hold_sel_q[g])
				pwm_out[g] <= 1'b0;
		end
	end

	// ************************************************************
	// Generic flag register
	// ************************************************************
	assign rd_flags = reg_rd && (reg_addr == pin_ctrl_pkg::REG_GEN_FLAGS);

	// Reset-seen flag survives pin reset so the edge is visible
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			gen_flags_q[pin_ctrl_pkg::FLAG_RESET_SEEN] <= 1'b0;
		else if (reset_fall)
			gen_flags_q[pin_ctrl_pkg::FLAG_RESET_SEEN] <= 1'b1;
		else if (rd_flags)
			gen_flags_q[pin_ctrl_pkg::FLAG_RESET_SEEN] <= 1'b0;
	end

	// Enable-low flag stays while the pin is low, read clears it after
	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
			gen_flags_q[pin_ctrl_pkg::FLAG_ENABLE_LOW] <= 1'b0;
		else if (!enable_s)
			gen_flags_q[pin_ctrl_pkg::FLAG_ENABLE_LOW] <= 1'b1;
		else if (rd_flags)
			gen_flags_q[pin_ctrl_pkg::FLAG_ENABLE_LOW] <= 1'b0;
	end

	// Sync pulse flag, a new pulse wins over the clearing read
	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
			gen_flags_q[pin_ctrl_pkg::FLAG_SYNC_SEEN] <= 1'b0;
		else if (sync_rise)
			gen_flags_q[pin_ctrl_pkg::FLAG_SYNC_SEEN] <= 1'b1;
		else if (rd_flags)
			gen_flags_q[pin_ctrl_pkg::FLAG_SYNC_SEEN] <= 1'b0;
	end

	// ************************************************************
	// Fault pin
	// ************************************************************
	assign fault_active = |(fault_in & ~fault_mask_q);

	// Open drain: drive low while an unmasked fault is present
	always_ff @(posedge sys_clk)
	begin
		if (core_rst)
		begin
			fault_pin_oe        <= 1'b0;
			fault_active_prev_q <= 1'b0;
		end
		else
		begin
			fault_pin_oe        <= fault_active;
			fault_active_prev_q <= fault_active;
		end
	end

	// The pin is only ever driven low
	always_ff @(posedge sys_clk)
	begin
		fault_pin_out <= 1'b0;
	end

	// ************************************************************
	// Interrupt status, mask and output
	// ************************************************************
	assign rd_irq = reg_rd && (reg_addr == pin_ctrl_pkg::REG_IRQ_STATUS);

	always_comb
	begin
		irq_events                              = '0;
		irq_events[pin_ctrl_pkg::IRQ_SYNC]       = sync_rise;
		irq_events[pin_ctrl_pkg::IRQ_ENABLE_LOW] = enable_fall;
		irq_events[pin_ctrl_pkg::IRQ_RESET_SEEN] = reset_fall;
		irq_events[pin_ctrl_pkg::IRQ_FAULT]      = fault_active && !fault_active_prev_q;
	end

	// Sticky status, read clears, a same-cycle event wins
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			irq_status_q <= '0;
		else if (rd_irq)
			irq_status_q <= irq_events;
		else
			irq_status_q <= irq_status_q | irq_events;
	end

	// Level interrupt from unmasked status
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			irq <= 1'b0;
		else
			irq <= |(irq_status_q & irq_mask_q);
	end

	// ************************************************************
	// Register read port
	// ************************************************************
	// Read mux; unaligned addresses in the channel ranges read their word, other unmapped ones read zero
	always_comb
	begin
		rdata_d = '0;
		case (reg_addr)
			pin_ctrl_pkg::REG_SLOT_LEN:   rdata_d[pin_ctrl_pkg::SLOT_W-1:0] = slot_len_q;
			pin_ctrl_pkg::REG_HOLD_SEL:   rdata_d[N-1:0] = hold_sel_q;
			pin_ctrl_pkg::REG_FAULT_MASK: rdata_d[N-1:0] = fault_mask_q;
			pin_ctrl_pkg::REG_GEN_FLAGS:  rdata_d[2:0] = gen_flags_q;
			pin_ctrl_pkg::REG_IRQ_STATUS: rdata_d[pin_ctrl_pkg::IRQ_W-1:0] = irq_status_q;
			pin_ctrl_pkg::REG_IRQ_MASK:   rdata_d[pin_ctrl_pkg::IRQ_W-1:0] = irq_mask_q;
			pin_ctrl_pkg::REG_PIN_STATE:
				rdata_d[12:0] = {tb_link.slot_idx, fault_active, sync_s,
					enable_s, 1'b0, pwm_out[3:0] | pwm_out[7:4]};
			default:
			begin
				if (reg_addr[7:5] == 3'h1)
					rdata_d[pin_ctrl_pkg::PHASE_W-1:0] = phase_q[reg_addr[4:2]];
				else if (reg_addr[7:5] == 3'h2)
					rdata_d[pin_ctrl_pkg::DUTY_W-1:0] = duty_q[reg_addr[4:2]];
			end
		endcase
	end

	// Read data stands the cycle after the strobe only
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			reg_rdata <= '0;
		else if (reg_rd)
			reg_rdata <= rdata_d;
		else
			reg_rdata <= '0;
	end
endmodule

`default_nettype wire

// ---- hw/pin_ctrl_pkg.sv ----
// Constants, register map and reset values for the global pin control block
package pin_ctrl_pkg;

	// ************************************************************
	// Sizes
	// ************************************************************
	localparam int CHANNELS    = 8;
	localparam int ADDR_W      = 8;
	localparam int SLOT_W      = 20;
	localparam int PHASE_W     = 5;
	localparam int DUTY_W      = 6;
	localparam int SYNC_STAGES = 2;

	// ************************************************************
	// Timing: clock rate and PWM frequency range
	// ************************************************************
	localparam longint CLK_HZ          = 100_000_000;
	localparam longint SLOTS_PER_PWM   = 32;
	localparam longint PWM_MIN_HZ      = 10;
	localparam longint PWM_NORM_MAX_HZ = 4000;
	localparam longint PWM_EXT_MAX_HZ  = 8000;
	// Longest slot rounds down, shortest slot rounds up
	localparam longint SLOT_MAX_CYC = CLK_HZ / (SLOTS_PER_PWM * PWM_MIN_HZ);
	localparam longint SLOT_MIN_CYC =
		(CLK_HZ + SLOTS_PER_PWM * PWM_EXT_MAX_HZ - 1) / (SLOTS_PER_PWM * PWM_EXT_MAX_HZ);
	localparam longint SLOT_DEF_CYC = CLK_HZ / (SLOTS_PER_PWM * PWM_NORM_MAX_HZ);
	localparam logic [SLOT_W-1:0] SLOT_MAX = SLOT_W'(SLOT_MAX_CYC);
	localparam logic [SLOT_W-1:0] SLOT_MIN = SLOT_W'(SLOT_MIN_CYC);
	localparam logic [SLOT_W-1:0] SLOT_DEF = SLOT_W'(SLOT_DEF_CYC);

	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [ADDR_W-1:0] REG_SLOT_LEN   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_HOLD_SEL   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_FAULT_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] REG_GEN_FLAGS  = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK   = 8'h14;
	localparam logic [ADDR_W-1:0] REG_PIN_STATE  = 8'h18;
	localparam logic [ADDR_W-1:0] REG_PHASE_BASE = 8'h20;
	localparam logic [ADDR_W-1:0] REG_DUTY_BASE  = 8'h40;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int FLAG_RESET_SEEN = 0;
	localparam int FLAG_ENABLE_LOW = 1;
	localparam int FLAG_SYNC_SEEN  = 2;
	localparam int IRQ_SYNC        = 0;
	localparam int IRQ_ENABLE_LOW  = 1;
	localparam int IRQ_RESET_SEEN  = 2;
	localparam int IRQ_FAULT       = 3;
	localparam int IRQ_W           = 4;
	localparam logic [CHANNELS-1:0] HOLD_SEL_DEF   = 8'h00;
	localparam logic [CHANNELS-1:0] FAULT_MASK_DEF = 8'h00;
	localparam logic [IRQ_W-1:0]    IRQ_MASK_DEF   = 4'h0;
	localparam logic [PHASE_W-1:0]  PHASE_DEF      = 5'h00;
	localparam logic [DUTY_W-1:0]   DUTY_DEF       = 6'h00;

endpackage

// ---- hw/timebase_if.sv ----
// Interface between the PWM timebase and the channel logic
`timescale 1ns/100ps
`default_nettype none

interface timebase_if;
	logic [pin_ctrl_pkg::SLOT_W-1:0]  slot_len;
	logic                             restart;
	logic [pin_ctrl_pkg::PHASE_W-1:0] slot_idx;

	// Timebase side
	modport source (input slot_len, input restart, output slot_idx);
	// Channel side
	modport sink (output slot_len, output restart, input slot_idx);
endinterface

`default_nettype wire

// ---- hw/pin_sync.sv ----
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] pin_in,
	output var  logic [WIDTH-1:0] pin_sync_q
);
	logic [WIDTH-1:0] meta_q;

	// ************************************************************
	// One two-flop chain per bit
	// ************************************************************
	for (genvar g = 0; g < WIDTH; g++)
	begin : g_bit
		always_ff @(posedge sys_clk)
		begin
			if (!reset_n)
			begin
				meta_q[g]     <= 1'b0;
				pin_sync_q[g] <= 1'b0;
			end
			else
			begin
				meta_q[g]     <= pin_in[g];
				pin_sync_q[g] <= meta_q[g];
			end
		end
	end
endmodule

`default_nettype wire

// ---- hw/pwm_timebase.sv ----
// PWM period timebase: 32 slots per period, restartable
`timescale 1ns/100ps
`default_nettype none

module pwm_timebase (
	// Clock and reset
	input  wire logic   sys_clk,
	input  wire logic   core_rst,
	// Timebase link
	timebase_if.source  tb
);
	logic [pin_ctrl_pkg::SLOT_W-1:0] cnt_q;
	logic                            slot_tick;

	// End of one slot: a one-cycle enable for the slot index
	assign slot_tick = (cnt_q >= tb.slot_len - 1'b1);

	// Cycle counter inside one slot
	always_ff @(posedge sys_clk)
	begin
		if (core_rst || tb.restart || slot_tick)
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 1'b1;
	end

	// Slot index, wraps after 32 slots; restart begins a fresh period
	always_ff @(posedge sys_clk)
	begin
		if (core_rst || tb.restart)
			tb.slot_idx <= '0;
		else if (slot_tick)
			tb.slot_idx <= tb.slot_idx + 1'b1;
	end
endmodule

`default_nettype wire

// ---- tb/pin_ctrl_props.sv ----
// Concurrent checks on the ports of the global pin control block
`timescale 1ns/100ps
`default_nettype none

module pin_ctrl_props (
	// Clock and reset
	input wire logic                                sys_clk,
	input wire logic                                reset_n,
	// Pins and supply monitor
	input wire logic                                reset_pin_n,
	input wire logic                                enable_pin,
	input wire logic                                phase_sync_pin,
	input wire logic                                supply_ok,
	input wire logic [pin_ctrl_pkg::CHANNELS-1:0]   fault_in,
	// Register port
	input wire logic [pin_ctrl_pkg::ADDR_W-1:0]     reg_addr,
	input wire logic [31:0]                         reg_wdata,
	input wire logic                                reg_wr,
	input wire logic                                reg_rd,
	input wire logic [31:0]                         reg_rdata,
	// Outputs
	input wire logic [pin_ctrl_pkg::CHANNELS-1:0]   pwm_out,
	input wire logic                                fault_pin_out,
	input wire logic                                fault_pin_oe,
	input wire logic                                irq
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	// ********************
	// Reset and enable
	// ********************
	a_pin_reset_off: assert property (!reset_pin_n [*5] |-> pwm_out == '0 && !fault_pin_oe)
		else $error("Outputs active while reset pin held low");
	a_supply_low_off: assert property (!supply_ok [*5] |-> pwm_out == '0)
		else $error("Outputs active while supply is low");
	a_enable_no_rise: assert property (!enable_pin [*4] |-> (pwm_out & ~$past(pwm_out)) == '0)
		else $error("Channel output rose while enable low");

	// ********************
	// Fault pin, bus and interrupt
	// ********************
	a_fault_has_cause: assert property (fault_pin_oe |-> $past(fault_in) != '0)
		else $error("Fault pin pulled without a fault");
	a_fault_pin_clear: assert property (fault_in == '0 |=> !fault_pin_oe)
		else $error("Fault pin pulled with no fault present");
	a_fault_drive_low: assert property (fault_pin_out == 1'b0)
		else $error("Fault pin driven high");
	a_idle_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("Read data not zero outside a read");
	a_irq_falls_access: assert property ($fell(irq) |->
		$past(reg_rd) || $past(reg_wr) || $past(reg_rd, 2) || $past(reg_wr, 2))
		else $error("Interrupt dropped without a register access");

	// Main scenarios reached
	cover property ($rose(fault_pin_oe));
	cover property ($rose(irq));
	cover property ($rose(pwm_out[1]));
endmodule

`default_nettype wire

// ---- tb/host_model.sv ----
// Host model driving the device control pins and the supply monitor
`timescale 1ns/100ps
`default_nettype none

module host_model (
	// Clock
	input  wire logic sys_clk,
	// Control pins
	output var  logic reset_pin_n,
	output var  logic enable_pin,
	output var  logic phase_sync_pin,
	output var  logic supply_ok
);
	// Supplies down and device held in reset at start
	initial
	begin
		reset_pin_n    = 1'b0;
		enable_pin     = 1'b0;
		phase_sync_pin = 1'b0;
		supply_ok      = 1'b0;
	end

	// Supplies settle before the reset pin is let go
	task automatic power_up();
		@(posedge sys_clk);
		supply_ok <= 1'b1;
		repeat (4) @(posedge sys_clk);
		reset_pin_n <= 1'b1;
		enable_pin  <= 1'b1;
	endtask

	// One lone sync pulse, four cycles wide, never a train
	task automatic sync_pulse();
		@(posedge sys_clk);
		phase_sync_pin <= 1'b1;
		repeat (4) @(posedge sys_clk);
		phase_sync_pin <= 1'b0;
	endtask

	// Reset pin low for n cycles
	task automatic pin_reset(input int n);
		@(posedge sys_clk);
		reset_pin_n <= 1'b0;
		repeat (n) @(posedge sys_clk);
		reset_pin_n <= 1'b1;
	endtask

	// Supply dip for n cycles
	task automatic supply_dip(input int n);
		@(posedge sys_clk);
		supply_ok <= 1'b0;
		repeat (n) @(posedge sys_clk);
		supply_ok <= 1'b1;
	endtask

	// Enable level change
	task automatic set_enable(input logic v);
		@(posedge sys_clk);
		enable_pin <= v;
	endtask
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking testbench for the global pin control block
`timescale 1ns/100ps
`default_nettype none

module testbench;
	// ********************
	// Signals
	// ********************
	logic                              sys_clk = 1'b0;
	logic                              reset_n = 1'b0;
	logic                              reset_pin_n;
	logic                              enable_pin;
	logic                              phase_sync_pin;
	logic                              supply_ok;
	logic [pin_ctrl_pkg::CHANNELS-1:0] fault_in = '0;
	logic [7:0]                        reg_addr = 8'h00;
	logic [31:0]                       reg_wdata = 32'h0;
	logic                              reg_wr = 1'b0;
	logic                              reg_rd = 1'b0;
	logic [31:0]                       reg_rdata;
	logic [pin_ctrl_pkg::CHANNELS-1:0] pwm_out;
	logic                              fault_pin_out;
	logic                              fault_pin_oe;
	logic                              irq;
	logic [31:0]                       rd_val;
	int                                mismatches = 0;
	int                                samples_checked = 0;

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	// Device and host
	global_pin_control_sync global_pin_control_sync_inst (.sys_clk(sys_clk), .reset_n(reset_n),
		.reset_pin_n(reset_pin_n), .enable_pin(enable_pin), .phase_sync_pin(phase_sync_pin),
		.supply_ok(supply_ok), .fault_in(fault_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out),
		.fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe), .irq(irq));
	host_model host_model_inst (.sys_clk(sys_clk), .reset_pin_n(reset_pin_n),
		.enable_pin(enable_pin), .phase_sync_pin(phase_sync_pin), .supply_ok(supply_ok));

	// ********************
	// Bus and check tasks
	// ********************
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		check(what, exp, rd_val);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ********************
	// Scenarios
	// ********************
	// Defaults, unmapped place and slot length limits
	task automatic t_defaults();
		rd(pin_ctrl_pkg::REG_GEN_FLAGS);
		rd(pin_ctrl_pkg::REG_IRQ_STATUS);
		rd_check("hold select", pin_ctrl_pkg::REG_HOLD_SEL, 32'(pin_ctrl_pkg::HOLD_SEL_DEF));
		rd_check("fault mask", pin_ctrl_pkg::REG_FAULT_MASK, 32'(pin_ctrl_pkg::FAULT_MASK_DEF));
		rd_check("slot length", pin_ctrl_pkg::REG_SLOT_LEN, 32'(pin_ctrl_pkg::SLOT_DEF));
		rd_check("unmapped", 8'hFC, 32'h0);
		wr(pin_ctrl_pkg::REG_SLOT_LEN, 32'h1);
		rd_check("slot low", pin_ctrl_pkg::REG_SLOT_LEN, 32'(pin_ctrl_pkg::SLOT_MIN));
		wr(pin_ctrl_pkg::REG_SLOT_LEN, 32'h000FFFFF);
		rd_check("slot high", pin_ctrl_pkg::REG_SLOT_LEN, 32'(pin_ctrl_pkg::SLOT_MAX));
		wr(pin_ctrl_pkg::REG_SLOT_LEN, 32'(pin_ctrl_pkg::SLOT_MIN));
	endtask

	// Sync restart, phase spacing and sync flag
	task automatic t_phase();
		int         n;
		int         t0 = 0;
		int         t1 = 0;
		logic [7:0] prev;
		wr(pin_ctrl_pkg::REG_PHASE_BASE, 32'h1);
		wr(pin_ctrl_pkg::REG_PHASE_BASE + 8'h04, 32'h4);
		wr(pin_ctrl_pkg::REG_DUTY_BASE, 32'h8);
		wr(pin_ctrl_pkg::REG_DUTY_BASE + 8'h04, 32'h8);
		rd(pin_ctrl_pkg::REG_GEN_FLAGS);
		host_model_inst.sync_pulse();
		#1;
		prev = pwm_out;
		for (n = 4; n < 16000 && t1 == 0; n++)
		begin
			@(posedge sys_clk);
			#1;
			if (pwm_out[0] && !prev[0] && t0 == 0)
				t0 = n + 1;
			if (pwm_out[1] && !prev[1])
				t1 = n + 1;
			prev = pwm_out;
		end
		if (t1 == 0)
		begin
			mismatches++;
			finish_test();
		end
		check("phase spacing", 32'(pin_ctrl_pkg::SLOT_MIN) * 32'd3, 32'(t1 - t0));
		check("restart delay", 32'h1, {31'h0, t0 >= 393 && t0 <= 397});
		rd_check("sync flag", pin_ctrl_pkg::REG_GEN_FLAGS, 32'h4);
		rd_check("sync flag clear", pin_ctrl_pkg::REG_GEN_FLAGS, 32'h0);
	endtask

	// Enable low: channel 0 turns off, channel 1 freezes
	task automatic t_enable();
		wr(pin_ctrl_pkg::REG_DUTY_BASE, 32'h20);
		wr(pin_ctrl_pkg::REG_DUTY_BASE + 8'h04, 32'h20);
		wr(pin_ctrl_pkg::REG_HOLD_SEL, 32'h2);
		host_model_inst.sync_pulse();
		wait_cyc(2000);
		rd(pin_ctrl_pkg::REG_GEN_FLAGS);
		check("outputs on", 32'h3, 32'(pwm_out[1:0]));
		host_model_inst.set_enable(1'b0);
		wait_cyc(6);
		check("outputs enable low", 32'h2, 32'(pwm_out[1:0]));
		rd_check("enable flag", pin_ctrl_pkg::REG_GEN_FLAGS, 32'h2);
		rd_check("enable flag held", pin_ctrl_pkg::REG_GEN_FLAGS, 32'h2);
		host_model_inst.set_enable(1'b1);
		wait_cyc(6);
		check("outputs enable high", 32'h3, 32'(pwm_out[1:0]));
		rd_check("enable flag last", pin_ctrl_pkg::REG_GEN_FLAGS, 32'h2);
		rd_check("enable flag clear", pin_ctrl_pkg::REG_GEN_FLAGS, 32'h0);
	endtask

	// Fault mask, fault pin and interrupt raise, mask and clear
	task automatic t_fault();
		rd(pin_ctrl_pkg::REG_IRQ_STATUS);
		wr(pin_ctrl_pkg::REG_FAULT_MASK, 32'h4);
		wr(pin_ctrl_pkg::REG_IRQ_MASK, 32'h0);
		fault_in <= 8'h04;
		wait_cyc(3);
		check("masked fault", 32'h0, 32'(fault_pin_oe));
		fault_in <= 8'h0C;
		wait_cyc(3);
		check("unmasked fault", 32'h1, 32'(fault_pin_oe));
		rd(pin_ctrl_pkg::REG_PIN_STATE);
		check("pin state", 32'hA0, rd_val & 32'hE0);
		check("irq masked", 32'h0, 32'(irq));
		wr(pin_ctrl_pkg::REG_IRQ_MASK, 32'h8);
		wait_cyc(2);
		check("irq raised", 32'h1, 32'(irq));
		rd_check("irq status", pin_ctrl_pkg::REG_IRQ_STATUS, 32'h8);
		wait_cyc(2);
		check("irq cleared", 32'h0, 32'(irq));
		fault_in <= 8'h00;
		wait_cyc(3);
		check("fault released", 32'h0, 32'(fault_pin_oe));
	endtask

	// Reset pin and supply dip restore defaults
	task automatic t_resets();
		wr(pin_ctrl_pkg::REG_HOLD_SEL, 32'hFF);
		host_model_inst.pin_reset(6);
		#1;
		check("outputs in reset", 32'h0, 32'(pwm_out));
		wait_cyc(6);
		rd_check("hold after reset", pin_ctrl_pkg::REG_HOLD_SEL, 32'h0);
		rd_check("duty after reset", pin_ctrl_pkg::REG_DUTY_BASE, 32'(pin_ctrl_pkg::DUTY_DEF));
		rd_check("reset seen", pin_ctrl_pkg::REG_GEN_FLAGS, 32'h1);
		rd_check("reset seen clear", pin_ctrl_pkg::REG_GEN_FLAGS, 32'h0);
		wr(pin_ctrl_pkg::REG_HOLD_SEL, 32'hFF);
		wr(pin_ctrl_pkg::REG_DUTY_BASE, 32'h20);
		host_model_inst.supply_dip(6);
		#1;
		check("outputs in dip", 32'h0, 32'(pwm_out));
		wait_cyc(6);
		rd_check("hold after dip", pin_ctrl_pkg::REG_HOLD_SEL, 32'h0);
	endtask

	// Main sequence
	initial
	begin
		host_model_inst.power_up();
		repeat (15) @(posedge sys_clk);
		reset_n <= 1'b1;
		wait_cyc(6);
		t_defaults();
		t_phase();
		t_enable();
		t_fault();
		t_resets();
		finish_test();
	end
endmodule

bind global_pin_control_sync pin_ctrl_props pin_ctrl_props_inst (.sys_clk(sys_clk),
	.reset_n(reset_n), .reset_pin_n(reset_pin_n), .enable_pin(enable_pin),
	.phase_sync_pin(phase_sync_pin), .supply_ok(supply_ok), .fault_in(fault_in),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .pwm_out(pwm_out), .fault_pin_out(fault_pin_out),
	.fault_pin_oe(fault_pin_oe), .irq(irq));

`default_nettype wire
